//--- hdl/pnv_pkg.sv
// Purpose: constants for the next-page and vendor register bank
// Assumes: 16-bit register words addressed by a 5-bit register number
// Notes: control words are kept as an indexed array of flip-flops
package pnv_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int MSG_W = 11;

    // register numbers
    localparam logic [4:0] ADDR_LOCAL_NP = 5'h07;
    localparam logic [4:0] ADDR_PARTNER_NP = 5'h08;
    localparam logic [4:0] ADDR_DIG_PWR = 5'h10;
    localparam logic [4:0] ADDR_AFE_CTL = 5'h11;
    localparam logic [4:0] ADDR_SYM_ERR = 5'h15;
    localparam logic [4:0] ADDR_STRAP_OVR = 5'h16;
    localparam logic [4:0] ADDR_EXP_CTL = 5'h18;

    // indices into the writable control array
    localparam int NUM_CTL = 5;
    localparam logic [2:0] CTL_LNP = 3'h0;
    localparam logic [2:0] CTL_DIG = 3'h1;
    localparam logic [2:0] CTL_AFE = 3'h2;
    localparam logic [2:0] CTL_STRAP = 3'h3;
    localparam logic [2:0] CTL_EXP = 3'h4;
    localparam logic [2:0] CTL_NONE = 3'h7;

    localparam logic [4:0] CTL_ADDR [NUM_CTL] = '{5'h07, 5'h10, 5'h11, 5'h16, 5'h18};
    // writable bits; everything else is read-only
    localparam logic [15:0] CTL_WMASK [NUM_CTL] = '{16'h37ff, 16'hffff, 16'hffff, 16'hfbff, 16'hffff};
    localparam logic [15:0] CTL_RST [NUM_CTL] = '{16'h2001, 16'h0000, 16'h0000, 16'h0001, 16'h0800};

    // field positions
    localparam int LNP_TOGGLE_BIT = 11;
    localparam int PNP_TOGGLE_BIT = 11;
    localparam int PLL_OFF_BIT = 4;
    localparam int SLOW_OSC_BIT = 5;
    localparam int FACTORY_BIT = 15;
    localparam int ENERGY_DETECT_POWER_DOWN_DIS_BIT = 11;

    // strap sampler waits for the three-stage synchroniser to fill
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef enum logic [2:0] {
        ST_FILL = 3'b001,
        ST_LATCH = 3'b010,
        ST_RUN = 3'b100
    } pnv_strap_e;
endpackage : pnv_pkg

//--- hdl/pnv_cnt_if.sv
// Purpose: carrier between the register bank and its error counter
// Assumes: single clock domain
// Notes: inc and clr are one-cycle pulses
interface pnv_cnt_if;
    logic inc;
    logic clr;
    logic [pnv_pkg::DATA_W-1:0] count;
    modport counter (input inc, input clr, output count);
    modport owner (output inc, output clr, input count);
endinterface : pnv_cnt_if

//--- hdl/pnv_err_counter.sv
// Purpose: symbol-error frame counter, cleared by a read
// Assumes: rst_n_in already synchronised to clk_in
// Notes: saturates instead of wrapping
module pnv_err_counter (
    input wire logic clk_in,
    input wire logic rst_n_in,
    pnv_cnt_if.counter cnt
);
    logic [pnv_pkg::DATA_W-1:0] count_q;
    logic [pnv_pkg::DATA_W-1:0] count_d;
    wire sat = &count_q;

    // count, read clears
    // an event in the clearing cycle survives as a count of one
    assign count_d = cnt.clr ? pnv_pkg::DATA_W'(cnt.inc) :
                     (cnt.inc && !sat) ? count_q + 1'b1 : count_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_q <= 16'h0000;
        end else begin
            count_q <= count_d;
        end
    end

    assign cnt.count = count_q;

    a_cnt_clear:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cnt.clr |=> count_q == pnv_pkg::DATA_W'($past(cnt.inc)))
        else $error("counter not cleared by read");

    a_cnt_step:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (cnt.inc && !cnt.clr && !sat) |=> count_q == $past(count_q) + 16'h0001)
        else $error("counter missed an event");
endmodule : pnv_err_counter

//--- hdl/pnv_regs.sv
// Purpose: next-page, power, oscillator, error-count and strap registers
// Assumes: negotiation engine and receive path run on CLK_IN
// Notes: the strap pin and the reset release are asynchronous and are synchronised here

// Functional notes
// - local toggle read-only, last transmitted toggle
// - local message 11 bits, resets to 001
// - partner next-page bit read-only, reset 0
// - partner acknowledge bit read-only, reset 0
// - partner message-page and ack2 bits read-only
// - partner toggle is inverse of transmitted toggle
// - partner message 11 bits read-only, reset 0
// - pll off in power-down when enabled
// - slow oscillator bit replaces crystal clock
// - slow oscillator forces analog power-down
// - 16-bit symbol-error frame counter, read clears
// - factory bit loaded from transmit clock strap
// - power-down disable bit, resets to 1
// - local second acknowledge bit is read-write
module pnv_regs (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [4:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [15:0] RDATA_OUT,
    input wire logic TX_PAGE_SENT_IN,
    input wire logic TX_TOGGLE_IN,
    input wire logic RX_PAGE_VALID_IN,
    input wire logic [15:0] RX_PAGE_IN,
    input wire logic SYM_ERR_FRAME_IN,
    input wire logic ENERGY_ABSENT_IN,
    input wire logic TRANSMIT_CLOCK_PIN_IN,
    output logic [15:0] LOCAL_NP_WORD_OUT,
    output logic ENERGY_DETECT_POWER_DOWN_OUT,
    output logic PLL_OFF_OUT,
    output logic SLOW_OSC_SEL_OUT,
    output logic ANALOG_PWRDN_OUT,
    output logic FACTORY_MODE_OUT
);
    // reset release
    logic [1:0] rst_sync_q;
    wire rst_n = rst_sync_q[1];

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    function automatic logic [2:0] ctl_index(input logic [4:0] addr);
        logic [2:0] idx;
        idx = pnv_pkg::CTL_NONE;
        for (int i = 0; i < pnv_pkg::NUM_CTL; i++) begin
            if (addr == pnv_pkg::CTL_ADDR[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : ctl_index

    wire [2:0] wr_idx = WR_IN ? ctl_index(ADDR_IN) : pnv_pkg::CTL_NONE;
    wire [2:0] rd_idx = ctl_index(ADDR_IN);

    // strap pin synchroniser; stage 0 feeds only stage 1
    logic [2:0] strap_sync_q;
    logic [1:0] settle_q;
    logic [1:0] settle_d;
    pnv_pkg::pnv_strap_e state_q;
    pnv_pkg::pnv_strap_e state_d;
    wire strap_agree = strap_sync_q[1] == strap_sync_q[2];
    wire strap_load = (state_q == pnv_pkg::ST_LATCH) && strap_agree;

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            strap_sync_q <= 3'h0;
        end else begin
            strap_sync_q <= {strap_sync_q[1:0], TRANSMIT_CLOCK_PIN_IN};
        end
    end

    always_comb begin
        state_d = state_q;
        settle_d = settle_q;
        case (state_q)
            pnv_pkg::ST_FILL: begin
                settle_d = settle_q + 2'h1;
                if (settle_q == pnv_pkg::STRAP_SETTLE) begin
                    state_d = pnv_pkg::ST_LATCH;
                end
            end
            pnv_pkg::ST_LATCH: begin
                if (strap_agree) begin
                    state_d = pnv_pkg::ST_RUN;
                end
            end
            pnv_pkg::ST_RUN: begin
                state_d = pnv_pkg::ST_RUN;
            end
            default: begin
                state_d = pnv_pkg::ST_FILL;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pnv_pkg::ST_FILL;
            settle_q <= 2'h0;
        end else begin
            state_q <= state_d;
            settle_q <= settle_d;
        end
    end

    // control words
    logic [15:0] ctl_q [pnv_pkg::NUM_CTL];
    logic [15:0] ctl_d [pnv_pkg::NUM_CTL];

    for (genvar g = 0; g < pnv_pkg::NUM_CTL; g++) begin : g_ctl
        wire sel = wr_idx == 3'(g);
        wire [15:0] merged = (ctl_q[g] & ~pnv_pkg::CTL_WMASK[g]) | (WDATA_IN & pnv_pkg::CTL_WMASK[g]);
        wire [15:0] written = sel ? merged : ctl_q[g];
        // strap value beats a write in the same cycle
        if (g == pnv_pkg::CTL_STRAP) begin : g_strap
            assign ctl_d[g] = strap_load ?
                {strap_sync_q[2], written[14:0]} : written;
        end else begin : g_plain
            assign ctl_d[g] = written;
        end

        // masked merge leaves read-only bits at default
        always_ff @(posedge CLK_IN or negedge rst_n) begin
            if (!rst_n) begin
                ctl_q[g] <= pnv_pkg::CTL_RST[g];
            end else begin
                ctl_q[g] <= ctl_d[g];
            end
        end
    end

    logic tog_q;

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            tog_q <= 1'b0;
        end else if (TX_PAGE_SENT_IN) begin
            tog_q <= TX_TOGGLE_IN;
        end
    end

    // toggle reported inverted from our last one
    logic [15:0] part_q;
    wire [15:0] part_d = {RX_PAGE_IN[15:12], ~tog_q, RX_PAGE_IN[pnv_pkg::MSG_W-1:0]};

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            part_q <= 16'h0000;
        end else if (RX_PAGE_VALID_IN) begin
            part_q <= part_d;
        end
    end

    // error counter
    pnv_cnt_if cnt_if ();
    assign cnt_if.inc = SYM_ERR_FRAME_IN;
    // a read of the counter clears it
    assign cnt_if.clr = RD_IN && (ADDR_IN == pnv_pkg::ADDR_SYM_ERR);

    pnv_err_counter u_err_counter (
        .clk_in(CLK_IN),
        .rst_n_in(rst_n),
        .cnt(cnt_if.counter)
    );

    // last sent toggle rides in bit 11 of the local word
    wire [15:0] lnp_view = ctl_q[pnv_pkg::CTL_LNP] | (16'(tog_q) << pnv_pkg::LNP_TOGGLE_BIT);

    // unmapped and reserved read as zero
    logic [15:0] rd_val;
    always_comb begin
        if (ADDR_IN == pnv_pkg::ADDR_LOCAL_NP) begin
            rd_val = lnp_view;
        end else if (ADDR_IN == pnv_pkg::ADDR_PARTNER_NP) begin
            rd_val = part_q;
        end else if (ADDR_IN == pnv_pkg::ADDR_SYM_ERR) begin
            rd_val = cnt_if.count;
        end else if (rd_idx != pnv_pkg::CTL_NONE) begin
            rd_val = ctl_q[rd_idx];
        end else begin
            rd_val = 16'h0000;
        end
    end

    // control effects
    // disable bit gates power-down entry
    wire energy_detect_power_down_d = ENERGY_ABSENT_IN && !ctl_q[pnv_pkg::CTL_EXP][pnv_pkg::ENERGY_DETECT_POWER_DOWN_DIS_BIT];
    wire pll_off_d = energy_detect_power_down_d && ctl_q[pnv_pkg::CTL_DIG][pnv_pkg::PLL_OFF_BIT];
    wire slow_d = ctl_q[pnv_pkg::CTL_AFE][pnv_pkg::SLOW_OSC_BIT];

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            RDATA_OUT <= 16'h0000;
            LOCAL_NP_WORD_OUT <= 16'h0000;
            ENERGY_DETECT_POWER_DOWN_OUT <= 1'b0;
            PLL_OFF_OUT <= 1'b0;
            SLOW_OSC_SEL_OUT <= 1'b0;
            ANALOG_PWRDN_OUT <= 1'b0;
            FACTORY_MODE_OUT <= 1'b0;
        end else begin
            RDATA_OUT <= RD_IN ? rd_val : 16'h0000;
            LOCAL_NP_WORD_OUT <= lnp_view;
            ENERGY_DETECT_POWER_DOWN_OUT <= energy_detect_power_down_d;
            PLL_OFF_OUT <= pll_off_d;
            SLOW_OSC_SEL_OUT <= slow_d;
            ANALOG_PWRDN_OUT <= slow_d;
            // a written zero clears factory mode
            FACTORY_MODE_OUT <= ctl_q[pnv_pkg::CTL_STRAP][pnv_pkg::FACTORY_BIT];
        end
    end

    a_local_toggle:
    assert property (@(posedge CLK_IN) disable iff (!rst_n)
        TX_PAGE_SENT_IN |=> ##1 LOCAL_NP_WORD_OUT[11] == $past(TX_TOGGLE_IN, 2))
        else $error("local toggle not tracking sent word");

    a_local_msg:
    assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (WR_IN && ADDR_IN == pnv_pkg::ADDR_LOCAL_NP) |=> ##1
        LOCAL_NP_WORD_OUT[10:0] == $past(WDATA_IN[10:0], 2))
        else $error("local message not written");

    a_partner_fields:
    assert property (@(posedge CLK_IN) disable iff (!rst_n)
        RX_PAGE_VALID_IN |=> part_q[15:12] == $past(RX_PAGE_IN[15:12])
        && part_q[10:0] == $past(RX_PAGE_IN[10:0]))
        else $error("partner word not captured");

    a_partner_toggle:
    assert property (@(posedge CLK_IN) disable iff (!rst_n)
        RX_PAGE_VALID_IN |=> part_q[pnv_pkg::PNP_TOGGLE_BIT] == !$past(tog_q))
        else $error("partner toggle not inverted");

    a_pll_off_gate:
    assert property (@(posedge CLK_IN) disable iff (!rst_n)
        PLL_OFF_OUT |-> ENERGY_DETECT_POWER_DOWN_OUT && $past(ctl_q[1][4]))
        else $error("pll off outside power-down");

    a_slow_osc_pd:
    assert property (@(posedge CLK_IN) disable iff (!rst_n)
        ANALOG_PWRDN_OUT == SLOW_OSC_SEL_OUT
        && ANALOG_PWRDN_OUT == $past(ctl_q[pnv_pkg::CTL_AFE][pnv_pkg::SLOW_OSC_BIT]))
        else $error("analog power-down not tied to slow oscillator");

    a_slow_osc_sel:
    assert property (@(posedge CLK_IN) disable iff (!rst_n)
        SLOW_OSC_SEL_OUT == $past(ctl_q[pnv_pkg::CTL_AFE][pnv_pkg::SLOW_OSC_BIT]))
        else $error("slow oscillator select not following control bit");

    a_strap_latch:
    assert property (@(posedge CLK_IN) disable iff (!rst_n)
        strap_load |=> ##1 FACTORY_MODE_OUT == $past(strap_sync_q[2], 2))
        else $error("strap value not latched");

    a_factory_clear:
    assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (WR_IN && ADDR_IN == pnv_pkg::ADDR_STRAP_OVR && !WDATA_IN[15] && !strap_load)
        |=> ##1 !FACTORY_MODE_OUT)
        else $error("factory mode not cleared");

    a_energy_detect_power_down_disable:
    assert property (@(posedge CLK_IN) disable iff (!rst_n)
        $past(ctl_q[4][11]) |-> !ENERGY_DETECT_POWER_DOWN_OUT)
        else $error("power-down entered while disabled");

    a_rdata_idle:
    assert property (@(posedge CLK_IN) disable iff (!rst_n)
        !RD_IN |=> RDATA_OUT == 16'h0000)
        else $error("read data outside read slot");

    // the toggle is merged in on read, so the stored bit 11 must stay clear
    a_reserved_ro:
    assert property (@(posedge CLK_IN) disable iff (!rst_n)
        ctl_q[pnv_pkg::CTL_LNP][15:14] == 2'h0 && !ctl_q[pnv_pkg::CTL_LNP][11]
        && !ctl_q[pnv_pkg::CTL_STRAP][10])
        else $error("read-only control bit changed");

    a_read_partner:
    assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (RD_IN && ADDR_IN == pnv_pkg::ADDR_PARTNER_NP) |=> RDATA_OUT == $past(part_q))
        else $error("partner word read back wrong");
endmodule : pnv_regs

//--- tb/pnv_engine_model.sv
// Purpose: negotiation engine and receive path as seen by the register bank
// Assumes: one clock, events are one-cycle pulses launched after a rising edge
// Notes: released data lines show the inverse of the last value, never a stale copy
module pnv_engine_model (
    input wire logic clk_in,
    output logic tx_sent_out,
    output logic tx_toggle_out,
    output logic rx_valid_out,
    output logic [15:0] rx_page_out,
    output logic sym_err_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        tx_sent_out = 1'b0;
        tx_toggle_out = 1'b0;
        rx_valid_out = 1'b0;
        rx_page_out = 16'h0000;
        sym_err_out = 1'b0;
    end

    task automatic send_tx(input logic t);
        @(posedge clk_in);
        tx_sent_out <= 1'b1;
        tx_toggle_out <= t;
        @(posedge clk_in);
        tx_sent_out <= 1'b0;
        tx_toggle_out <= ~t;
    endtask : send_tx

    task automatic recv_page(input logic [15:0] p);
        @(posedge clk_in);
        rx_valid_out <= 1'b1;
        rx_page_out <= p;
        @(posedge clk_in);
        rx_valid_out <= 1'b0;
        rx_page_out <= ~p;
    endtask : recv_page

    task automatic sym_errs(input int n);
        repeat (n) begin
            @(posedge clk_in);
            sym_err_out <= 1'b1;
        end
        @(posedge clk_in);
        sym_err_out <= 1'b0;
    endtask : sym_errs
endmodule : pnv_engine_model

//--- tb/tb.sv
// Purpose: self-checking bench for the next-page and vendor register bank
// Assumes: strap pin pulled high, so factory mode is latched after reset
// Notes: derived outputs are checked a few cycles after the write that causes them
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic energy_absent = 1'b0;
    logic strap = 1'b1;
    logic tx_sent, tx_tog, rx_vld, sym_err, energy_detect_power_down, pll_off, slow_osc, afe_pd, factory, tog;
    logic [15:0] rx_page, rdata, lnp_word, v, w;
    logic [4:0] rw_regs [3] = '{5'h10, 5'h11, 5'h18};
    int n_fail = 0;
    int comparisons = 0;
    int n;

    initial begin
        forever #50 clk = ~clk;
    end

    pnv_regs u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .TX_PAGE_SENT_IN(tx_sent), .TX_TOGGLE_IN(tx_tog),
        .RX_PAGE_VALID_IN(rx_vld), .RX_PAGE_IN(rx_page), .SYM_ERR_FRAME_IN(sym_err),
        .ENERGY_ABSENT_IN(energy_absent), .TRANSMIT_CLOCK_PIN_IN(strap), .LOCAL_NP_WORD_OUT(lnp_word),
        .ENERGY_DETECT_POWER_DOWN_OUT(energy_detect_power_down), .PLL_OFF_OUT(pll_off), .SLOW_OSC_SEL_OUT(slow_osc),
        .ANALOG_PWRDN_OUT(afe_pd), .FACTORY_MODE_OUT(factory));

    pnv_engine_model u_eng (.clk_in(clk), .tx_sent_out(tx_sent), .tx_toggle_out(tx_tog),
        .rx_valid_out(rx_vld), .rx_page_out(rx_page), .sym_err_out(sym_err));

    function automatic logic [15:0] exp_lnp(input logic [15:0] d, input logic t);
        // bits 15, 14 and 11 are not writable; 11 shows the last sent toggle
        return (d & 16'h37ff) | {4'h0, t, 11'h000};
    endfunction : exp_lnp

    function automatic logic [15:0] exp_pnp(input logic [15:0] p, input logic t);
        return {p[15:12], ~t, p[10:0]};
    endfunction : exp_pnp

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic finish_test;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        finish_test();
    end

    initial begin
        void'($urandom(32'h6538));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        chk({15'h0000, factory}, 16'h0001);
        chk(lnp_word, 16'h2001);
        rd_chk(5'h07, 16'h2001);
        rd_chk(5'h08, 16'h0000);
        rd_chk(5'h10, 16'h0000);
        rd_chk(5'h11, 16'h0000);
        rd_chk(5'h15, 16'h0000);
        rd_chk(5'h16, 16'h8001);
        rd_chk(5'h18, 16'h0800);
        // the controller leaves factory mode by clearing the bit
        reg_wr(5'h16, 16'h0001);
        settle();
        chk({15'h0000, factory}, 16'h0000);
        v = 16'($urandom);
        reg_wr(5'h16, v);
        rd_chk(5'h16, v & 16'hfbff);
        reg_wr(5'h1f, 16'hffff);
        rd_chk(5'h1f, 16'h0000);
        foreach (rw_regs[i]) begin
            v = 16'($urandom);
            reg_wr(rw_regs[i], v);
            rd_chk(rw_regs[i], v);
        end
        for (int i = 0; i < 6; i++) begin
            tog = 1'($urandom_range(1));
            v = (i == 0) ? 16'hffff : 16'($urandom);
            u_eng.send_tx(tog);
            reg_wr(5'h07, v);
            rd_chk(5'h07, exp_lnp(v, tog));
            chk(lnp_word, exp_lnp(v, tog));
            w = (i == 0) ? 16'hffff : 16'($urandom);
            u_eng.recv_page(w);
            rd_chk(5'h08, exp_pnp(w, tog));
            reg_wr(5'h08, ~w);
            rd_chk(5'h08, exp_pnp(w, tog));
        end
        n = 1 + $urandom_range(40);
        u_eng.sym_errs(n);
        rd_chk(5'h15, 16'(n));
        rd_chk(5'h15, 16'h0000);
        // an error frame in the clearing cycle survives the read
        fork
            u_eng.sym_errs(2);
            rd_chk(5'h15, 16'h0000);
        join
        rd_chk(5'h15, 16'h0002);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            energy_absent <= i[0];
            reg_wr(5'h18, {4'h0, i[1], 11'h000});
            reg_wr(5'h10, {11'h000, i[2], 4'h0});
            settle();
            chk({14'h0000, energy_detect_power_down, pll_off}, {14'h0000, i[0] & ~i[1], i[0] & ~i[1] & i[2]});
        end
        for (int i = 0; i < 2; i++) begin
            reg_wr(5'h11, {10'h000, i[0], 5'h00});
            settle();
            chk({14'h0000, slow_osc, afe_pd}, {14'h0000, i[0], i[0]});
        end
        finish_test();
    end
endmodule : tb
